// ==== auf_consts.svh ====
// Purpose: Shared constants for the host serial port and debug console.
// Assumes: 50 MHz core clock; frames are 8N1 with the line idling high.
// Notes: Times are kept in their own units; cycle counts derive from them.
// Notes on behaviour
// - Edge mode: 9600/115200 baud, handshake edges matter
// - All packets: flag framed, one stop, no parity
// - Edge mode uses six signals, no gap
// - Edge mode: request enables receiver, then grant
// - Companion drops request, waits grant release
// - Device requests transmit; companion grants when ready
// - Edge mode: send after grant falling edge
// - Edge mode: drop request, await grant release
// - Level mode: grant level-sensitive, receive unhandshaked
// - Level mode: receive works with request inactive
// - Level mode: device requests; grant may stay low
// - Level mode: send when grant sampled low
// - Level mode: hold request released for gap
// - Console: two wires, fixed 9600, 8N1
// - Handshake mode taken from boot configuration
// - Idle watching, wake on activity, report awake
`ifndef AUF_CONSTS_SVH
`define AUF_CONSTS_SVH

`define AUF_CLK_HZ 50000000
`define AUF_CLK_NS 20
`define AUF_BAUD_SLOW 9600
`define AUF_BAUD_FAST 115200
`define AUF_BIT_FAST_CYC (`AUF_CLK_HZ / `AUF_BAUD_FAST)
`define AUF_TX_GAP_US 1000
`define AUF_TX_GAP_CYC ((`AUF_TX_GAP_US * 1000 + `AUF_CLK_NS - 1) / `AUF_CLK_NS)
`define AUF_DATA_BITS 4'h9
`define AUF_HDLC_FLAG 8'h7E
`define AUF_LINE_IDLE 1'b1
`define AUF_START_BIT 1'b0
`define AUF_CON_STOP_CNT 4'h9

`endif

// ==== auf_pkg.sv ====
// Purpose: Types shared by the host serial port and its buffer.
// Assumes: Nothing beyond the constants header.
// Notes: Byte words carry a packet mark beside the data.
`default_nettype none
package auf_pkg;
  typedef enum logic {AUF_MODE_EDGE, AUF_MODE_LEVEL} auf_mode_e;
  typedef enum logic [1:0] {AUF_RX_IDLE, AUF_RX_START, AUF_RX_DATA, AUF_RX_STOP} auf_rx_state_e;
  typedef enum logic [2:0] {AUF_TX_IDLE, AUF_TX_REQ, AUF_TX_SEND, AUF_TX_WAIT_REL,
    AUF_TX_GAP} auf_tx_state_e;
  typedef logic [15:0] auf_tmr_t;
  // Mark: last byte of a packet on transmit, flag byte on receive
  typedef struct packed {
    logic mark;
    logic [7:0] data;
  } auf_byte_s;
endpackage
`default_nettype wire

// ==== auf_buf2.sv ====
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Flags are registered so ready and valid come straight from flops.
`timescale 1ns/1ns
`default_nettype none
module auf_buf2
  import auf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire auf_byte_s in_data,
  output var logic in_ready,
  output var logic out_valid,
  output auf_byte_s out_data,
  input wire logic out_ready
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  auf_byte_s slot1_reg;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Occupancy after this cycle's moves
  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  // Head and second slot; second slot refills the head on a pop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_reg <= 2'h0;
      out_valid <= 1'b0;
      in_ready <= 1'b1;
      out_data <= '0;
      slot1_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      out_valid <= (cnt_next != 2'h0);
      in_ready <= (cnt_next != 2'h2); // Full stalls the source
      if (push && (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop))) begin
        out_data <= in_data;
      end else if (pop && cnt_reg == 2'h2) begin
        out_data <= slot1_reg;
      end
      if (push && cnt_reg == 2'h1 && !pop) begin
        slot1_reg <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// ==== auf_host_port.sv ====
// Purpose: Host serial port with two handshake modes, plus debug console.
// Assumes: Pins synchronous to core_clk; mode and rate straps steady at reset.
// Notes: A packet is sent whole; the user must keep its bytes flowing.
`timescale 1ns/1ns
`default_nettype none
`include "auf_consts.svh"
module auf_host_port
  import auf_pkg::*;
#(
  parameter int unsigned BIT_SLOW_CYC = `AUF_CLK_HZ / `AUF_BAUD_SLOW,
  parameter int unsigned TX_GAP_CYC = `AUF_TX_GAP_CYC
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mode_level_sel,
  input wire logic baud_fast_sel,
  input wire logic host_rx_serial,
  output var logic host_tx_serial,
  input wire logic host_rx_request_n,
  output var logic host_rx_grant_n,
  output var logic dev_tx_request_n,
  input wire logic dev_tx_grant_n,
  input wire logic tx_valid,
  input wire auf_byte_s tx_byte,
  output var logic tx_ready,
  output var logic rx_valid,
  output auf_byte_s rx_byte,
  input wire logic rx_ready,
  output var logic rx_frame_err,
  output var logic rx_overrun,
  output var logic port_awake,
  input wire logic con_rx_serial,
  output var logic con_tx_serial,
  input wire logic con_tx_valid,
  input wire logic [7:0] con_tx_data,
  output var logic con_tx_ready,
  output var logic con_rx_valid,
  output var logic [7:0] con_rx_data
);
  localparam auf_tmr_t SLOW_CYC = auf_tmr_t'(BIT_SLOW_CYC);
  localparam auf_tmr_t FAST_CYC = auf_tmr_t'(`AUF_BIT_FAST_CYC);
  localparam auf_tmr_t GAP_CYC = auf_tmr_t'(TX_GAP_CYC);

  logic cfg_done_reg;
  auf_mode_e mode_reg;
  logic fast_reg;
  logic edge_mode;
  auf_tmr_t bit_full;
  logic req_prev_reg;
  logic grant_prev_reg;
  logic rxd_prev_reg;
  logic rx_en_reg;
  auf_rx_state_e rx_state_reg;
  auf_tmr_t rx_tmr_reg;
  logic [2:0] rx_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic rxb_push_reg;
  auf_byte_s rxb_word_reg;
  logic rxb_in_ready;
  auf_tx_state_e tx_state_reg;
  auf_tmr_t gap_tmr_reg;
  logic last_sent_reg;
  logic txb_out_valid;
  auf_byte_s txb_word;
  logic tx_load;
  logic ser_busy_reg;
  logic [8:0] ser_shift_reg;
  logic [3:0] ser_bits_reg;
  auf_tmr_t ser_tmr_reg;
  logic ser_done;
  logic [8:0] con_shift_reg;
  logic [3:0] con_bits_reg;
  auf_tmr_t con_tmr_reg;
  logic con_rx_act_reg;
  auf_tmr_t con_rx_tmr_reg;
  logic [3:0] con_rx_cnt_reg;
  logic [7:0] con_rx_sh_reg;
  logic con_rxd_prev_reg;
  auf_tmr_t hi_cnt_reg;

  // Straps caught once after reset release, never changed while running
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_done_reg <= 1'b0;
      mode_reg <= AUF_MODE_EDGE;
      fast_reg <= 1'b0;
    end else if (!cfg_done_reg) begin
      cfg_done_reg <= 1'b1;
      mode_reg <= mode_level_sel ? AUF_MODE_LEVEL : AUF_MODE_EDGE;
      fast_reg <= baud_fast_sel;
    end
  end

  assign edge_mode = (mode_reg == AUF_MODE_EDGE);
  assign bit_full = fast_reg ? FAST_CYC : SLOW_CYC;

  // Previous pin levels for edge detection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_prev_reg <= 1'b1;
      grant_prev_reg <= 1'b1;
      rxd_prev_reg <= `AUF_LINE_IDLE;
      con_rxd_prev_reg <= `AUF_LINE_IDLE;
    end else begin
      req_prev_reg <= host_rx_request_n;
      grant_prev_reg <= dev_tx_grant_n;
      rxd_prev_reg <= host_rx_serial;
      con_rxd_prev_reg <= con_rx_serial;
    end
  end

  // Receive handshake: edge mode grants only after the receiver is on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_en_reg <= 1'b0;
      host_rx_grant_n <= 1'b1;
    end else if (cfg_done_reg) begin
      if (!edge_mode) begin
        rx_en_reg <= 1'b1;
        host_rx_grant_n <= host_rx_request_n;
      end else begin
        if (req_prev_reg && !host_rx_request_n && host_rx_grant_n) begin
          rx_en_reg <= 1'b1;
        end else if (host_rx_request_n && rx_state_reg == AUF_RX_IDLE) begin
          rx_en_reg <= 1'b0;
        end
        if (rx_en_reg && !host_rx_request_n) begin
          host_rx_grant_n <= 1'b0;
        end else if (host_rx_request_n && rx_state_reg == AUF_RX_IDLE) begin
          host_rx_grant_n <= 1'b1;
        end
      end
    end
  end

  // Receive deserializer: mid-bit sampling, LSB first, one stop bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_state_reg <= AUF_RX_IDLE;
      rx_tmr_reg <= '0;
      rx_cnt_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rxb_push_reg <= 1'b0;
      rxb_word_reg <= '0;
      rx_frame_err <= 1'b0;
    end else begin
      rxb_push_reg <= 1'b0;
      rx_frame_err <= 1'b0;
      case (rx_state_reg)
        AUF_RX_IDLE: begin
          if (rx_en_reg && rxd_prev_reg && host_rx_serial == `AUF_START_BIT) begin
            rx_state_reg <= AUF_RX_START;
            rx_tmr_reg <= (bit_full >> 1) - 16'h0001;
          end
        end
        AUF_RX_START: begin
          if (rx_tmr_reg != 16'h0000) begin
            rx_tmr_reg <= rx_tmr_reg - 16'h0001;
          end else if (host_rx_serial != `AUF_START_BIT) begin
            rx_state_reg <= AUF_RX_IDLE; // Glitch, not a start bit
          end else begin
            rx_state_reg <= AUF_RX_DATA;
            rx_cnt_reg <= 3'h0;
            rx_tmr_reg <= bit_full - 16'h0001;
          end
        end
        AUF_RX_DATA: begin
          if (rx_tmr_reg != 16'h0000) begin
            rx_tmr_reg <= rx_tmr_reg - 16'h0001;
          end else begin
            rx_shift_reg <= {host_rx_serial, rx_shift_reg[7:1]};
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            rx_tmr_reg <= bit_full - 16'h0001;
            if (rx_cnt_reg == 3'h7) begin
              rx_state_reg <= AUF_RX_STOP;
            end
          end
        end
        AUF_RX_STOP: begin
          if (rx_tmr_reg != 16'h0000) begin
            rx_tmr_reg <= rx_tmr_reg - 16'h0001;
          end else begin
            rx_state_reg <= AUF_RX_IDLE;
            if (host_rx_serial == `AUF_LINE_IDLE) begin
              rxb_push_reg <= 1'b1;
              rxb_word_reg <= '{mark: (rx_shift_reg == `AUF_HDLC_FLAG), data: rx_shift_reg};
            end else begin
              rx_frame_err <= 1'b1; // Bad stop bit drops the byte
            end
          end
        end
        default: rx_state_reg <= AUF_RX_IDLE;
      endcase
    end
  end

  // No pause is allowed on the line, so a full buffer loses the byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_overrun <= 1'b0;
    end else begin
      rx_overrun <= rxb_push_reg && !rxb_in_ready;
    end
  end

  auf_buf2 u_rx_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(rxb_push_reg),
    .in_data(rxb_word_reg),
    .in_ready(rxb_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_byte),
    .out_ready(rx_ready)
  );

  auf_buf2 u_tx_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_data(tx_byte),
    .in_ready(tx_ready),
    .out_valid(txb_out_valid),
    .out_data(txb_word),
    .out_ready(tx_load)
  );

  assign tx_load = (tx_state_reg == AUF_TX_SEND) && !ser_busy_reg && !last_sent_reg &&
    txb_out_valid;
  assign ser_done = ser_busy_reg && ser_bits_reg == 4'h0 && ser_tmr_reg == 16'h0000;

  // Transmit handshake and packet sequencing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state_reg <= AUF_TX_IDLE;
      dev_tx_request_n <= 1'b1;
      gap_tmr_reg <= '0;
      last_sent_reg <= 1'b0;
    end else begin
      case (tx_state_reg)
        AUF_TX_IDLE: begin
          if (cfg_done_reg && txb_out_valid) begin
            dev_tx_request_n <= 1'b0;
            tx_state_reg <= AUF_TX_REQ;
          end
        end
        AUF_TX_REQ: begin
          if (edge_mode ? (grant_prev_reg && !dev_tx_grant_n) : !dev_tx_grant_n) begin
            tx_state_reg <= AUF_TX_SEND;
          end
        end
        AUF_TX_SEND: begin
          if (tx_load) begin
            last_sent_reg <= txb_word.mark;
          end
          if (ser_done && last_sent_reg) begin
            dev_tx_request_n <= 1'b1;
            last_sent_reg <= 1'b0;
            gap_tmr_reg <= GAP_CYC - 16'h0001;
            tx_state_reg <= edge_mode ? AUF_TX_WAIT_REL : AUF_TX_GAP;
          end
        end
        AUF_TX_WAIT_REL: begin
          if (dev_tx_grant_n) begin
            tx_state_reg <= AUF_TX_IDLE;
          end
        end
        AUF_TX_GAP: begin
          if (gap_tmr_reg == 16'h0000) begin
            tx_state_reg <= AUF_TX_IDLE;
          end else begin
            gap_tmr_reg <= gap_tmr_reg - 16'h0001;
          end
        end
        default: tx_state_reg <= AUF_TX_IDLE;
      endcase
    end
  end

  // Transmit serializer: start bit, eight data bits LSB first, stop bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ser_busy_reg <= 1'b0;
      host_tx_serial <= `AUF_LINE_IDLE;
      ser_shift_reg <= 9'h000;
      ser_bits_reg <= 4'h0;
      ser_tmr_reg <= '0;
    end else if (tx_load) begin
      ser_busy_reg <= 1'b1;
      host_tx_serial <= `AUF_START_BIT;
      ser_shift_reg <= {`AUF_LINE_IDLE, txb_word.data};
      ser_bits_reg <= `AUF_DATA_BITS;
      ser_tmr_reg <= bit_full - 16'h0001;
    end else if (ser_busy_reg) begin
      if (ser_tmr_reg != 16'h0000) begin
        ser_tmr_reg <= ser_tmr_reg - 16'h0001;
      end else if (ser_bits_reg == 4'h0) begin
        ser_busy_reg <= 1'b0;
      end else begin
        host_tx_serial <= ser_shift_reg[0];
        ser_shift_reg <= {`AUF_LINE_IDLE, ser_shift_reg[8:1]};
        ser_bits_reg <= ser_bits_reg - 4'h1;
        ser_tmr_reg <= bit_full - 16'h0001;
      end
    end
  end

  // Console transmit, fixed slow rate regardless of the rate strap
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      con_tx_ready <= 1'b1;
      con_tx_serial <= `AUF_LINE_IDLE;
      con_shift_reg <= 9'h000;
      con_bits_reg <= 4'h0;
      con_tmr_reg <= '0;
    end else if (con_tx_ready && con_tx_valid) begin
      con_tx_ready <= 1'b0;
      con_tx_serial <= `AUF_START_BIT;
      con_shift_reg <= {`AUF_LINE_IDLE, con_tx_data};
      con_bits_reg <= `AUF_DATA_BITS;
      con_tmr_reg <= SLOW_CYC - 16'h0001;
    end else if (!con_tx_ready) begin
      if (con_tmr_reg != 16'h0000) begin
        con_tmr_reg <= con_tmr_reg - 16'h0001;
      end else if (con_bits_reg == 4'h0) begin
        con_tx_ready <= 1'b1;
      end else begin
        con_tx_serial <= con_shift_reg[0];
        con_shift_reg <= {`AUF_LINE_IDLE, con_shift_reg[8:1]};
        con_bits_reg <= con_bits_reg - 4'h1;
        con_tmr_reg <= SLOW_CYC - 16'h0001;
      end
    end
  end

  // Console receive; no back-pressure, a byte is a one-cycle pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      con_rx_act_reg <= 1'b0;
      con_rx_tmr_reg <= '0;
      con_rx_cnt_reg <= 4'h0;
      con_rx_sh_reg <= 8'h00;
      con_rx_valid <= 1'b0;
      con_rx_data <= 8'h00;
    end else begin
      con_rx_valid <= 1'b0;
      if (!con_rx_act_reg) begin
        if (con_rxd_prev_reg && con_rx_serial == `AUF_START_BIT) begin
          con_rx_act_reg <= 1'b1;
          con_rx_cnt_reg <= 4'h0;
          con_rx_tmr_reg <= (SLOW_CYC >> 1) - 16'h0001;
        end
      end else if (con_rx_tmr_reg != 16'h0000) begin
        con_rx_tmr_reg <= con_rx_tmr_reg - 16'h0001;
      end else if (con_rx_cnt_reg == `AUF_CON_STOP_CNT) begin
        con_rx_act_reg <= 1'b0;
        con_rx_valid <= (con_rx_serial == `AUF_LINE_IDLE);
        con_rx_data <= con_rx_sh_reg;
      end else if (con_rx_cnt_reg == 4'h0 && con_rx_serial != `AUF_START_BIT) begin
        con_rx_act_reg <= 1'b0;
      end else begin
        if (con_rx_cnt_reg != 4'h0) begin
          con_rx_sh_reg <= {con_rx_serial, con_rx_sh_reg[7:1]};
        end
        con_rx_cnt_reg <= con_rx_cnt_reg + 4'h1;
        con_rx_tmr_reg <= SLOW_CYC - 16'h0001;
      end
    end
  end

  // Awake while anything moves; low lets the power manager doze the port
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      port_awake <= 1'b0;
    end else begin
      port_awake <= (rx_state_reg != AUF_RX_IDLE) || (tx_state_reg != AUF_TX_IDLE) ||
        !host_rx_grant_n || !con_tx_ready || con_rx_act_reg;
    end
  end

  // Cycles the transmit request has stood released, saturating
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hi_cnt_reg <= 16'hFFFF;
    end else if (!dev_tx_request_n) begin
      hi_cnt_reg <= 16'h0000;
    end else if (hi_cnt_reg != 16'hFFFF) begin
      hi_cnt_reg <= hi_cnt_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence grant_fall_s;
    edge_mode && tx_state_reg == AUF_TX_REQ && $fell(dev_tx_grant_n);
  endsequence
  sequence packet_end_s;
    tx_state_reg == AUF_TX_SEND && ser_done && last_sent_reg;
  endsequence

  rx_grant_order_a: assert property (edge_mode && $rose(rx_en_reg) && !host_rx_request_n
    |=> !host_rx_grant_n)
    else $error("grant not given after enable");
  rx_grant_enabled_a: assert property (edge_mode && !host_rx_grant_n |-> rx_en_reg)
    else $error("grant without receiver on");
  tx_edge_start_a: assert property (grant_fall_s |=> tx_state_reg == AUF_TX_SEND)
    else $error("falling grant did not start send");
  tx_level_ignored_a: assert property (edge_mode && tx_state_reg == AUF_TX_REQ
    && !$fell(dev_tx_grant_n) |=> tx_state_reg != AUF_TX_SEND)
    else $error("edge mode started on level");
  tx_level_start_a: assert property (!edge_mode && tx_state_reg == AUF_TX_REQ
    && !dev_tx_grant_n |=> tx_state_reg == AUF_TX_SEND)
    else $error("low grant did not start send");
  tx_release_end_a: assert property (packet_end_s |=> dev_tx_request_n ##1 dev_tx_request_n)
    else $error("request held after packet");
  tx_wait_grant_a: assert property (tx_state_reg == AUF_TX_WAIT_REL && !dev_tx_grant_n
    |=> dev_tx_request_n)
    else $error("request before grant release");
  tx_gap_hold_a: assert property (!edge_mode && $fell(dev_tx_request_n)
    |-> hi_cnt_reg >= GAP_CYC)
    else $error("transmit gap too short");
  tx_start_bit_a: assert property ($rose(ser_busy_reg)
    |-> host_tx_serial == `AUF_START_BIT ##1 host_tx_serial == `AUF_START_BIT)
    else $error("no start bit");
  tx_stop_bit_a: assert property (ser_busy_reg && ser_bits_reg == 4'h0 |-> host_tx_serial)
    else $error("stop bit not high");
  con_start_bit_a: assert property ($fell(con_tx_ready) |-> !con_tx_serial)
    else $error("console start bit missing");
endmodule
`default_nettype wire

// ==== auf_companion.sv ====
// Purpose: Companion controller model on the far side of the host port.
// Assumes: Host port strapped to match; bit time set by the bench.
// Notes: Drives just after the clock edge; grant may be slow, prompt or tied low.
`timescale 1ns/1ns
`default_nettype none
module auf_companion (
  input wire logic core_clk,
  input wire logic host_tx_serial,
  input wire logic host_rx_grant_n,
  input wire logic dev_tx_request_n,
  output var logic host_rx_serial,
  output var logic host_rx_request_n,
  output var logic dev_tx_grant_n
);
  int bit_cyc = 16;
  int grant_delay = 2;
  int rx_gap = 40;
  int grant_wait = 0;
  bit hold_low = 1'b0;
  bit armed = 1'b1;
  logic [7:0] rxq[$];

  // Lines idle high, handshakes inactive
  initial begin
    host_rx_serial = 1'b1;
    host_rx_request_n = 1'b1;
    dev_tx_grant_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #2;
    end
  endtask

  // One character, start bit, data lsb first, one stop, no parity
  task automatic send_byte(input logic [7:0] b);
    host_rx_serial = 1'b0;
    tick(bit_cyc);
    for (int i = 0; i < 8; i++) begin
      host_rx_serial = b[i];
      tick(bit_cyc);
    end
    host_rx_serial = 1'b1;
    tick(bit_cyc);
  endtask

  // Whole packet without pauses, with or without the receive handshake
  task automatic send_pkt(input logic [7:0] d[$], input bit hs);
    if (hs) begin
      host_rx_request_n = 1'b0;
      for (grant_wait = 0; grant_wait < 50 && host_rx_grant_n !== 1'b0; grant_wait++) begin
        tick(1);
      end
    end
    foreach (d[i]) send_byte(d[i]);
    if (hs) begin
      host_rx_request_n = 1'b1;
      for (int i = 0; i < 50 && host_rx_grant_n !== 1'b1; i++) tick(1);
    end else begin
      tick(rx_gap);
    end
  endtask

  // One grant per request; dropped once the first byte is in
  always begin
    int n0;
    @(posedge core_clk);
    #2;
    if (hold_low) begin
      dev_tx_grant_n = 1'b0;
    end else if (dev_tx_request_n === 1'b0 && armed) begin
      armed = 1'b0;
      tick(grant_delay);
      dev_tx_grant_n = 1'b0;
      n0 = rxq.size();
      while (rxq.size() == n0 && dev_tx_request_n === 1'b0) tick(1);
      dev_tx_grant_n = 1'b1;
    end else if (dev_tx_request_n === 1'b1) begin
      armed = 1'b1;
      dev_tx_grant_n = 1'b1;
    end
  end

  // Mid-bit sampling receiver; stop bit is not judged here
  always begin
    logic [7:0] b;
    @(posedge core_clk);
    if (host_tx_serial === 1'b0) begin
      repeat (bit_cyc / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge core_clk);
        b[i] = host_tx_serial;
      end
      repeat (bit_cyc) @(posedge core_clk);
      rxq.push_back(b);
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the host serial port.
// Assumes: Shortened bit and gap counts; fast rate fixed at 434 cycles.
// Notes: Console output is looped back into its own input.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import auf_pkg::*;
;
  localparam int BIT = 16;
  localparam int GAP = 20;
  localparam int FAST = 434;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode_level_sel = 1'b0;
  logic baud_fast_sel = 1'b0;
  wire logic host_rx_serial;
  wire logic host_rx_request_n;
  wire logic dev_tx_grant_n;
  logic host_tx_serial, host_rx_grant_n, dev_tx_request_n;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b1;
  logic tx_ready, rx_valid, rx_frame_err, rx_overrun, port_awake;
  auf_byte_s tx_byte = '0;
  auf_byte_s rx_byte;
  logic con_tx_serial, con_tx_ready, con_rx_valid;
  logic con_tx_valid = 1'b0;
  logic [7:0] con_tx_data = 8'h00;
  logic [7:0] con_rx_data;
  int fails = 0;
  int n_checks = 0;
  int ovr = 0;
  int ferr = 0;
  int hi_run = 0;
  int last_gap = 0;
  auf_byte_s rxq[$];

  // Console loopback exercises both console directions
  auf_host_port #(.BIT_SLOW_CYC(BIT), .TX_GAP_CYC(GAP)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .mode_level_sel(mode_level_sel),
    .baud_fast_sel(baud_fast_sel), .host_rx_serial(host_rx_serial),
    .host_tx_serial(host_tx_serial), .host_rx_request_n(host_rx_request_n),
    .host_rx_grant_n(host_rx_grant_n), .dev_tx_request_n(dev_tx_request_n),
    .dev_tx_grant_n(dev_tx_grant_n), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .rx_frame_err(rx_frame_err), .rx_overrun(rx_overrun), .port_awake(port_awake),
    .con_rx_serial(con_tx_serial), .con_tx_serial(con_tx_serial),
    .con_tx_valid(con_tx_valid), .con_tx_data(con_tx_data), .con_tx_ready(con_tx_ready),
    .con_rx_valid(con_rx_valid), .con_rx_data(con_rx_data)
  );

  auf_companion comp (
    .core_clk(core_clk), .host_tx_serial(host_tx_serial),
    .host_rx_grant_n(host_rx_grant_n), .dev_tx_request_n(dev_tx_request_n),
    .host_rx_serial(host_rx_serial), .host_rx_request_n(host_rx_request_n),
    .dev_tx_grant_n(dev_tx_grant_n)
  );

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // Received bytes, lost-byte pulses and request idle stretches
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_byte);
    if (rx_overrun === 1'b1) ovr++;
    if (rx_frame_err === 1'b1) ferr++;
    if (dev_tx_request_n === 1'b1) begin
      hi_run++;
    end else begin
      if (hi_run != 0) last_gap = hi_run;
      hi_run = 0;
    end
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #2;
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Straps are only taken at reset, so each mode needs its own reset
  task automatic restart(input logic lvl, input logic fast);
    rst_n = 1'b0;
    mode_level_sel = lvl;
    baud_fast_sel = fast;
    comp.bit_cyc = fast ? FAST : BIT;
    tick(4);
    rst_n = 1'b1;
    hi_run = 0;
    tick(2);
    rxq.delete();
    comp.rxq.delete();
  endtask

  // Holds valid until the edge that sees ready high
  task automatic push(input logic [7:0] d, input logic last);
    tx_valid = 1'b1;
    tx_byte = '{mark: last, data: d};
    for (int i = 0; i < 5000 && tx_ready !== 1'b1; i++) tick(1);
    tick(1);
  endtask

  task automatic wait_n(input int n);
    for (int i = 0; i < 20000 && comp.rxq.size() < n; i++) tick(1);
  endtask

  task automatic sc_edge_rx();
    logic [7:0] d[$] = '{8'h7E, 8'hA5, 8'h3C, 8'h7E};
    restart(1'b0, 1'b0);
    chk_bit("idle awake", 1'b0, port_awake);
    chk_bit("rx grant idle", 1'b1, host_rx_grant_n);
    comp.send_pkt(d, 1'b1);
    chk_bit("rx grant prompt", 1'b1, comp.grant_wait <= 3);
    chk_bit("rx grant released", 1'b1, host_rx_grant_n);
    tick(4);
    chk_bit("awake after", 1'b0, port_awake);
    chk_byte("rx count", 8'h04, 8'(rxq.size()));
    foreach (d[i]) begin
      chk_byte("rx data", d[i], rxq[i].data);
      chk_bit("rx flag mark", d[i] == 8'h7E, rxq[i].mark);
    end
  endtask

  task automatic sc_edge_tx();
    logic [7:0] e[$] = '{8'h7E, 8'h5A, 8'hC3, 8'h7E};
    comp.hold_low = 1'b0;
    comp.grant_delay = 100;
    restart(1'b0, 1'b0);
    push(e[0], 1'b0);
    push(e[1], 1'b0);
    tick(1);
    chk_bit("tx buffer full", 1'b0, tx_ready);
    chk_bit("tx request", 1'b0, dev_tx_request_n);
    chk_bit("awake busy", 1'b1, port_awake);
    chk_bit("tx line before grant", 1'b1, host_tx_serial);
    push(e[2], 1'b0);
    push(e[3], 1'b1);
    tx_valid = 1'b0;
    wait_n(4);
    foreach (e[i]) chk_byte("tx data", e[i], comp.rxq[i]);
    for (int i = 0; i < 100 && dev_tx_request_n !== 1'b1; i++) tick(1);
    chk_bit("tx request released", 1'b1, dev_tx_request_n);
  endtask

  task automatic sc_level();
    logic [7:0] e[$] = '{8'h11, 8'h22, 8'h33};
    logic [7:0] d[$] = '{8'hA1, 8'hB2, 8'hC3};
    comp.hold_low = 1'b1;
    restart(1'b1, 1'b1);
    push(e[0], 1'b0);
    push(e[1], 1'b1);
    push(e[2], 1'b1);
    tx_valid = 1'b0;
    wait_n(3);
    foreach (e[i]) chk_byte("level tx data", e[i], comp.rxq[i]);
    chk_bit("tx gap", 1'b1, last_gap >= GAP + 1);
    rx_ready = 1'b0;
    ovr = 0;
    comp.send_pkt(d, 1'b0);
    chk_byte("overrun pulses", 8'h01, 8'(ovr));
    rx_ready = 1'b1;
    tick(3);
    chk_byte("level rx count", 8'h02, 8'(rxq.size()));
    chk_byte("level rx first", d[0], rxq[0].data);
    chk_byte("level rx second", d[1], rxq[1].data);
    chk_byte("frame errors", 8'h00, 8'(ferr));
  endtask

  task automatic sc_console();
    int n;
    logic [7:0] got;
    got = 8'h00;
    restart(1'b0, 1'b0);
    con_tx_data = 8'hC5;
    con_tx_valid = 1'b1;
    tick(1);
    con_tx_valid = 1'b0;
    chk_bit("console busy", 1'b0, con_tx_ready);
    for (n = 1; n < 400 && con_tx_ready !== 1'b1; n++) begin
      if (con_rx_valid === 1'b1) got = con_rx_data;
      tick(1);
    end
    chk_byte("console loopback", 8'hC5, got);
    chk_bit("console bit time", 1'b1, n >= 10 * BIT && n <= 10 * BIT + 3);
  endtask

  // Watchdog sized well above the expected run of about 30000 cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    complete_run();
  end

  initial begin
    sc_edge_rx();
    sc_edge_tx();
    sc_level();
    sc_console();
    complete_run();
  end
endmodule
`default_nettype wire
